// file: verilog/osf_supervisor.sv
// Setpoint, strap decode, power-good, clock select and APB registers
module osf_supervisor #(
  parameter int unsigned RESTART_CYCLES = osf_pkg::RESTART_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] voltStrapCode,
  input wire logic [2:0] freqStrapCode,
  input wire logic ctrlPin,
  input wire logic syncIn,
  input wire logic shareMode,
  input wire logic twoPhase,
  input wire osf_pkg::osf_mv_t voutMv,
  input wire osf_pkg::osf_amp_t ioutDa,
  input wire logic rampDone,
  output logic outputEnable,
  output osf_pkg::osf_mv_t targetMv,
  output logic outputGoodOut,
  output logic outputGoodOe,
  output logic syncOut,
  output logic syncOe,
  output logic switchClk,
  output logic [10:0] freqKhz,
  output logic [11:0] effFreqKhz,
  output logic hiccupActive
);
  import osf_pkg::*;

  function automatic osf_mv_t pctOf(input osf_mv_t mv, input logic [7:0] p);
    logic [20:0] prod;
    prod = 21'(mv) * 21'(p);
    return 13'(prod / 21'd100);
  endfunction
  function automatic osf_mv_t minMv(input osf_mv_t a, input osf_mv_t b);
    return (a < b) ? a : b;
  endfunction
  function automatic logic isMapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= REG_STRAP);
  endfunction

  // Only tabulated codes are legal; anything else falls back to the open level
  function automatic osf_mv_t strapVolt(input logic [5:0] c);
    osf_mv_t v;
    unique case (c)
      6'd0: v = 13'd1000;
      6'd1: v = 13'd1200;
      6'd2: v = 13'd900;
      6'd3: v = 13'd600;
      6'd4: v = 13'd650;
      6'd5: v = 13'd700;
      6'd6: v = 13'd750;
      6'd7: v = 13'd800;
      6'd8: v = 13'd850;
      6'd9: v = 13'd900;
      6'd10: v = 13'd950;
      6'd11: v = 13'd1000;
      6'd12: v = 13'd1050;
      6'd13: v = 13'd1100;
      6'd14: v = 13'd1150;
      6'd15: v = 13'd1200;
      6'd16: v = 13'd1250;
      6'd17: v = 13'd1300;
      6'd18: v = 13'd1400;
      6'd19: v = 13'd1500;
      6'd20: v = 13'd1600;
      6'd21: v = 13'd1700;
      6'd22: v = 13'd1800;
      6'd23: v = 13'd1900;
      6'd24: v = 13'd2000;
      6'd25: v = 13'd2100;
      6'd26: v = 13'd2200;
      6'd27: v = 13'd2300;
      6'd28: v = 13'd2500;
      6'd29: v = 13'd2800;
      6'd30: v = 13'd3000;
      6'd31: v = 13'd3300;
      6'd32: v = 13'd4000;
      6'd33: v = 13'd5000;
      default: v = 13'd1200;
    endcase
    return v;
  endfunction

  function automatic logic [10:0] strapFreq(input logic [2:0] c);
    logic [10:0] f;
    unique case (c)
      3'd0: f = 11'd400;
      3'd1: f = 11'd432;
      3'd2: f = 11'd457;
      3'd3: f = 11'd533;
      3'd4: f = 11'd571;
      3'd5: f = 11'd615;
      3'd6: f = 11'd727;
      3'd7: f = 11'd800;
    endcase
    return f;
  endfunction

  function automatic osf_mv_t bandCeil(input osf_mv_t held);
    osf_mv_t c;
    if (held < 13'd988) c = 13'd1200;
    else if (held < 13'd1383) c = 13'd1700;
    else if (held < 13'd1975) c = 13'd2500;
    else if (held < 13'd2398) c = 13'd2970;
    else if (held < 13'd2963) c = 13'd3680;
    else if (held < 13'd3753) c = 13'd4650;
    else c = 13'd5000;
    return c;
  endfunction

  typedef struct packed {
    logic [12:0] pinMeta, pinSync;
    logic [1:0] initCnt;
    logic initDone;
    osf_mv_t strapMv;
    logic [2:0] freqCode;
    logic opOn;
    logic [1:0] margin;
    logic [2:0] onoff;
    osf_mv_t voutCmd, trim, voutMax, marginHi, marginLo, ovLim, uvLim, pgOn;
    logic [3:0] faultAct;
    osf_amp_t ocLim, ucLim;
    logic [15:0] pgDelay;
    logic openDrain;
    logic [15:0] freqReg;
    logic [1:0] syncMode;
    logic clearPulse, wasOn;
    osf_mv_t heldMv;
    logic [15:0] pgCnt;
    logic [6:0] pgUnit;
    logic pg;
    logic [17:0] phaseAcc;
    logic intClk, outEn;
    osf_mv_t target;
    logic pgOut, pgOe, syncO, syncE, swClk;
    logic [10:0] freq;
    logic [11:0] effFreq;
    logic hiccup;
    logic [31:0] rdata;
    logic ready, slverr;
  } osf_main_s;

  osf_main_s s_q, s_d;
  osf_fault_if flt ();

  osf_fault_guard #(.RESTART_CYCLES(RESTART_CYCLES)) u_guard (.clk_sys(clk_sys), .rst(rst),
    .flt(flt));

  logic ctrlS, syncS, shareS, twoPhS, pinActive, access, wr;
  osf_mv_t base, reqMv, ceilMv;
  logic signed [14:0] sum;
  logic [17:0] step;

  assign ctrlS = s_q.pinSync[9];
  assign syncS = s_q.pinSync[10];
  assign shareS = s_q.pinSync[11];
  assign twoPhS = s_q.pinSync[12];
  assign pinActive = s_q.onoff[ONOFF_POL_BIT] ? ctrlS : ~ctrlS;
  assign access = psel && penable && s_q.ready;
  assign wr = access && pwrite && isMapped(paddr);

  assign flt.enableReq = s_q.initDone &&
    (!s_q.onoff[ONOFF_PIN_BIT] || pinActive) && (!s_q.onoff[ONOFF_BUS_BIT] || s_q.opOn);
  assign flt.rampDone = rampDone;
  assign flt.ovTrip = voutMv > s_q.ovLim;
  assign flt.uvTrip = voutMv < s_q.uvLim;
  assign flt.ocTrip = ioutDa > s_q.ocLim;
  assign flt.ucTrip = ioutDa < s_q.ucLim;
  assign flt.hiccupSel = shareS ? 4'h0 : s_q.faultAct;
  assign flt.clearFaults = s_q.clearPulse;

  always_comb begin
    s_d = s_q;
    s_d.pinMeta = {twoPhase, shareMode, syncIn, ctrlPin, freqStrapCode, voltStrapCode};
    s_d.pinSync = s_q.pinMeta;
    s_d.clearPulse = 1'b0;
    // Strap captured once after the synchroniser has filled
    if (!s_q.initDone) begin
      s_d.initCnt = s_q.initCnt + 2'h1;
      if (s_q.initCnt == INIT_CAPTURE) begin
        s_d.initDone = 1'b1;
        s_d.strapMv = strapVolt(s_q.pinSync[5:0]);
        s_d.freqCode = s_q.pinSync[8:6];
        s_d.voutCmd = strapVolt(s_q.pinSync[5:0]);
        s_d.voutMax = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_MAX);
        s_d.marginHi = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_MARGIN_HI);
        s_d.marginLo = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_MARGIN_LO);
        s_d.ovLim = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_OV);
        s_d.uvLim = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_UV);
        s_d.pgOn = pctOf(strapVolt(s_q.pinSync[5:0]), PCT_PG_ON);
      end
    end

    // One wait state: pready rises in the second access cycle
    s_d.ready = psel && penable && !s_q.ready;
    s_d.slverr = psel && penable && !s_q.ready && !isMapped(paddr);
    s_d.rdata = 32'h0;
    if (psel && penable && !s_q.ready && !pwrite) begin
      unique case (paddr)
        REG_OPERATION: s_d.rdata = {29'h0, s_q.margin, s_q.opOn};
        REG_ONOFF: s_d.rdata = {29'h0, s_q.onoff};
        REG_VOUT_CMD: s_d.rdata = {19'h0, s_q.voutCmd};
        REG_TRIM: s_d.rdata = {19'h0, s_q.trim};
        REG_VOUT_MAX: s_d.rdata = {19'h0, s_q.voutMax};
        REG_MARGIN_HI: s_d.rdata = {19'h0, s_q.marginHi};
        REG_MARGIN_LO: s_d.rdata = {19'h0, s_q.marginLo};
        REG_OV_LIMIT: s_d.rdata = {19'h0, s_q.ovLim};
        REG_UV_LIMIT: s_d.rdata = {19'h0, s_q.uvLim};
        REG_PG_ON: s_d.rdata = {19'h0, s_q.pgOn};
        REG_FAULT_ACT: s_d.rdata = {28'h0, s_q.faultAct};
        REG_OC_LIMIT: s_d.rdata = {20'h0, s_q.ocLim};
        REG_UC_LIMIT: s_d.rdata = {20'h0, s_q.ucLim};
        REG_PG_DELAY: s_d.rdata = {16'h0, s_q.pgDelay};
        REG_USER_CFG: s_d.rdata = {31'h0, s_q.openDrain};
        REG_FREQ: s_d.rdata = {16'h0, s_q.freqReg};
        REG_SYNC_CFG: s_d.rdata = {30'h0, s_q.syncMode};
        REG_STATUS: s_d.rdata = {24'h0, flt.hiccupActive, flt.regulating, s_q.pg,
          s_q.initDone, flt.faultFlags};
        REG_STRAP: s_d.rdata = {16'h0, s_q.freqCode, s_q.strapMv};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        REG_OPERATION: begin
          s_d.opOn = pwdata[OP_ON_BIT];
          s_d.margin = pwdata[OP_MARGIN_LSB +: 2];
        end
        REG_ONOFF: s_d.onoff = pwdata[2:0];
        REG_VOUT_CMD: s_d.voutCmd = pwdata[12:0];
        REG_TRIM: s_d.trim = pwdata[12:0];
        REG_VOUT_MAX: s_d.voutMax = pwdata[12:0];
        REG_MARGIN_HI: s_d.marginHi = pwdata[12:0];
        REG_MARGIN_LO: s_d.marginLo = pwdata[12:0];
        REG_OV_LIMIT: s_d.ovLim = pwdata[12:0];
        REG_UV_LIMIT: s_d.uvLim = pwdata[12:0];
        REG_PG_ON: s_d.pgOn = pwdata[12:0];
        REG_FAULT_ACT: s_d.faultAct = pwdata[3:0];
        REG_OC_LIMIT: s_d.ocLim = pwdata[11:0];
        REG_UC_LIMIT: s_d.ucLim = pwdata[11:0];
        REG_PG_DELAY: s_d.pgDelay = pwdata[15:0];
        REG_USER_CFG: s_d.openDrain = pwdata[0];
        REG_FREQ: s_d.freqReg = pwdata[15:0];
        REG_SYNC_CFG: s_d.syncMode = pwdata[1:0];
        REG_CLEAR: s_d.clearPulse = 1'b1;
        default: s_d.clearPulse = 1'b0;
      endcase
    end

    // Setpoint path
    if (s_q.margin == MARGIN_HIGH) base = s_q.marginHi;
    else if (s_q.margin == MARGIN_LOW) base = s_q.marginLo;
    else base = s_q.voutCmd;
    sum = $signed({2'b00, base}) + $signed({{2{s_q.trim[12]}}, s_q.trim});
    reqMv = sum[14] ? 13'h0 : (sum[13] ? 13'h1fff : sum[12:0]);
    ceilMv = minMv(pctOf(s_q.strapMv, PCT_MAX), s_q.voutMax);
    s_d.wasOn = flt.outputOn;
    // Band held from enable; host keeps the command still around enable
    if (flt.outputOn && !s_q.wasOn) begin
      s_d.heldMv = minMv(reqMv, ceilMv);
    end
    if (flt.outputOn) begin
      ceilMv = minMv(ceilMv, bandCeil(s_d.heldMv));
      if (reqMv < FLOOR_MV) reqMv = FLOOR_MV;
    end
    s_d.target = minMv(reqMv, ceilMv);
    s_d.outEn = flt.outputOn;
    s_d.hiccup = flt.hiccupActive;

    // Power-good with on-delay and hysteresis, forced low outside regulation
    if (!flt.regulating || |flt.faultFlags) begin
      s_d.pg = 1'b0;
      s_d.pgCnt = 16'h0;
      s_d.pgUnit = 7'h0;
    end else if (s_q.pg) begin
      if (voutMv < s_q.uvLim) s_d.pg = 1'b0;
    end else if (voutMv >= s_q.pgOn) begin
      if (s_q.pgCnt >= s_q.pgDelay) begin
        s_d.pg = 1'b1;
      end else if (s_q.pgUnit == 7'(PG_UNIT_CYCLES - 1)) begin
        s_d.pgUnit = 7'h0;
        s_d.pgCnt = s_q.pgCnt + 16'h1;
      end else begin
        s_d.pgUnit = s_q.pgUnit + 7'h1;
      end
    end else begin
      s_d.pgCnt = 16'h0;
      s_d.pgUnit = 7'h0;
    end
    s_d.pgOut = s_q.openDrain ? 1'b0 : s_d.pg;
    s_d.pgOe = s_q.openDrain ? !s_d.pg : 1'b1;

    // Frequency and internal switching clock
    s_d.freq = s_q.freqReg[FREQ_OVR_BIT] ? s_q.freqReg[10:0] : strapFreq(s_q.freqCode);
    s_d.effFreq = twoPhS ? {s_q.freq, 1'b0} : {1'b0, s_q.freq};
    step = {6'h0, s_q.freq, 1'b0};
    if (s_q.phaseAcc + step >= 18'(CLK_KHZ)) begin
      s_d.phaseAcc = s_q.phaseAcc + step - 18'(CLK_KHZ);
      s_d.intClk = !s_q.intClk;
    end else begin
      s_d.phaseAcc = s_q.phaseAcc + step;
    end
    s_d.syncE = (s_q.syncMode == SYNC_OUTPUT);
    s_d.syncO = s_d.syncE && s_q.intClk;
    s_d.swClk = (s_q.syncMode == SYNC_INPUT) ? syncS : s_q.intClk;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.onoff <= ONOFF_RST;
      s_q.faultAct <= FAULT_ACT_RST;
      s_q.ocLim <= OC_LIMIT_RST;
      s_q.ucLim <= UC_LIMIT_RST;
      s_q.pgDelay <= PG_DELAY_RST;
      s_q.pgOe <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign outputEnable = s_q.outEn;
  assign targetMv = s_q.target;
  assign outputGoodOut = s_q.pgOut;
  assign outputGoodOe = s_q.pgOe;
  assign syncOut = s_q.syncO;
  assign syncOe = s_q.syncE;
  assign switchClk = s_q.swClk;
  assign freqKhz = s_q.freq;
  assign effFreqKhz = s_q.effFreq;
  assign hiccupActive = s_q.hiccup;
endmodule

// file: verilog/osf_pkg.sv
// Constants and types shared by the setpoint and fault supervisor
package osf_pkg;
  typedef logic [12:0] osf_mv_t;
  typedef logic signed [11:0] osf_amp_t;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned PG_UNIT_NS = 1000;
  localparam int unsigned PG_UNIT_CYCLES = PG_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned RESTART_MS = 20;
  localparam int unsigned RESTART_CYCLES = RESTART_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [7:0] REG_OPERATION = 8'h00;
  localparam logic [7:0] REG_ONOFF = 8'h04;
  localparam logic [7:0] REG_VOUT_CMD = 8'h08;
  localparam logic [7:0] REG_TRIM = 8'h0c;
  localparam logic [7:0] REG_VOUT_MAX = 8'h10;
  localparam logic [7:0] REG_MARGIN_HI = 8'h14;
  localparam logic [7:0] REG_MARGIN_LO = 8'h18;
  localparam logic [7:0] REG_OV_LIMIT = 8'h1c;
  localparam logic [7:0] REG_UV_LIMIT = 8'h20;
  localparam logic [7:0] REG_PG_ON = 8'h24;
  localparam logic [7:0] REG_FAULT_ACT = 8'h28;
  localparam logic [7:0] REG_OC_LIMIT = 8'h2c;
  localparam logic [7:0] REG_UC_LIMIT = 8'h30;
  localparam logic [7:0] REG_PG_DELAY = 8'h34;
  localparam logic [7:0] REG_USER_CFG = 8'h38;
  localparam logic [7:0] REG_FREQ = 8'h3c;
  localparam logic [7:0] REG_SYNC_CFG = 8'h40;
  localparam logic [7:0] REG_STATUS = 8'h44;
  localparam logic [7:0] REG_CLEAR = 8'h48;
  localparam logic [7:0] REG_STRAP = 8'h4c;
  localparam int unsigned OP_ON_BIT = 0;
  localparam int unsigned OP_MARGIN_LSB = 1;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;
  localparam int unsigned ONOFF_POL_BIT = 0;
  localparam int unsigned ONOFF_PIN_BIT = 1;
  localparam int unsigned ONOFF_BUS_BIT = 2;
  localparam int unsigned FREQ_OVR_BIT = 15;
  localparam logic [1:0] SYNC_INPUT = 2'h1;
  localparam logic [1:0] SYNC_OUTPUT = 2'h2;
  localparam logic [2:0] ONOFF_RST = 3'h3;
  localparam logic [3:0] FAULT_ACT_RST = 4'h3;
  localparam osf_amp_t OC_LIMIT_RST = 12'sh190;
  localparam osf_amp_t UC_LIMIT_RST = -12'sh0c8;
  localparam logic [15:0] PG_DELAY_RST = 16'h0001;
  localparam logic [7:0] PCT_MAX = 8'd115;
  localparam logic [7:0] PCT_OV = 8'd110;
  localparam logic [7:0] PCT_MARGIN_HI = 8'd105;
  localparam logic [7:0] PCT_MARGIN_LO = 8'd95;
  localparam logic [7:0] PCT_PG_ON = 8'd90;
  localparam logic [7:0] PCT_UV = 8'd85;
  localparam osf_mv_t FLOOR_MV = 13'd200;
  localparam logic [1:0] INIT_CAPTURE = 2'h2;
endpackage

// file: verilog/osf_fault_if.sv
// Signals between the supervisor and its fault sequencer
interface osf_fault_if;
  logic enableReq;
  logic rampDone;
  logic ovTrip;
  logic uvTrip;
  logic ocTrip;
  logic ucTrip;
  logic [3:0] hiccupSel;
  logic clearFaults;
  logic outputOn;
  logic regulating;
  logic hiccupActive;
  logic [3:0] faultFlags;
  modport ctrl(output enableReq, rampDone, ovTrip, uvTrip, ocTrip, ucTrip, hiccupSel,
    clearFaults, input outputOn, regulating, hiccupActive, faultFlags);
  modport guard(input enableReq, rampDone, ovTrip, uvTrip, ocTrip, ucTrip, hiccupSel,
    clearFaults, output outputOn, regulating, hiccupActive, faultFlags);
endinterface

// file: verilog/osf_fault_guard.sv
// Output on/off sequencer with latch-off and hiccup fault responses
module osf_fault_guard #(
  parameter int unsigned RESTART_CYCLES = osf_pkg::RESTART_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  osf_fault_if.guard flt
);
  import osf_pkg::*;
  typedef enum logic [2:0] {OFF, RAMP, ON, HICCUP, LATCHED} osf_state_e;
  typedef struct packed {
    osf_state_e state;
    logic [31:0] cnt;
    logic [3:0] flags;
  } osf_guard_s;
  osf_guard_s s_q, s_d;
  logic [3:0] trip;
  logic anyTrip;

  always_comb begin
    s_d = s_q;
    // Under-voltage is blind during the ramp, overload only once regulating
    trip = {flt.ucTrip, flt.ocTrip, flt.uvTrip, flt.ovTrip};
    if (s_q.state == RAMP) begin
      trip = {3'h0, flt.ovTrip};
    end else if (s_q.state != ON) begin
      trip = 4'h0;
    end
    anyTrip = |trip;
    // Set beats clear so a fault in the clearing cycle survives
    s_d.flags = (flt.clearFaults ? 4'h0 : s_q.flags) | trip;
    unique case (s_q.state)
      OFF: begin
        if (flt.enableReq) begin
          s_d.state = RAMP;
        end
      end
      RAMP, ON: begin
        if (!flt.enableReq) begin
          s_d.state = OFF;
        end else if (anyTrip) begin
          s_d.cnt = 32'h0;
          s_d.state = |(trip & ~flt.hiccupSel) ? LATCHED : HICCUP;
        end else if (s_q.state == RAMP && flt.rampDone) begin
          s_d.state = ON;
        end
      end
      HICCUP: begin
        s_d.cnt = s_q.cnt + 32'h1;
        if (!flt.enableReq) begin
          s_d.state = OFF;
        end else if (s_q.cnt >= RESTART_CYCLES - 1) begin
          s_d.state = RAMP;
        end
      end
      LATCHED: begin
        if (!flt.enableReq || flt.clearFaults) begin
          s_d.state = OFF;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '{state: OFF, cnt: 32'h0, flags: 4'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign flt.outputOn = (s_q.state == RAMP) || (s_q.state == ON);
  assign flt.regulating = (s_q.state == ON);
  assign flt.hiccupActive = (s_q.state == HICCUP);
  assign flt.faultFlags = s_q.flags;
endmodule

// file: tb/osf_supervisor_props.sv
// Concurrent checks on the supervisor's ports
module osf_supervisor_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic outputEnable,
  input wire logic outputGoodOut,
  input wire logic outputGoodOe,
  input wire logic hiccupActive
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held too long");
  property p_rdy_access;
    pready |-> psel && penable;
  endproperty
  a_rdy_access: assert property (p_rdy_access) else $error("pready outside access");
  property p_answer;
    $rose(penable) && psel |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("pready not in second access cycle");
  property p_err_map;
    pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h4c);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero when idle");
  property p_od_drive;
    outputGoodOut |-> outputGoodOe;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("good pin high undriven");
  property p_hic_off;
    hiccupActive [*2] |-> !outputEnable;
  endproperty
  a_hic_off: assert property (p_hic_off) else $error("output on in hiccup wait");
  property p_pg_ramp;
    $rose(outputEnable) |-> !outputGoodOut [*3];
  endproperty
  a_pg_ramp: assert property (p_pg_ramp) else $error("good flag high in ramp");
  property p_pg_drop;
    $fell(outputEnable) |-> ##[0:2] !outputGoodOut;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("good flag kept after off");
endmodule
bind osf_supervisor osf_supervisor_props props (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .outputEnable(outputEnable), .outputGoodOut(outputGoodOut), .outputGoodOe(outputGoodOe),
  .hiccupActive(hiccupActive));

// file: tb/osf_load_model.sv
// Behavioural power stage and load beside the supervisor
module osf_load_model
  import osf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic outputEnable,
  input wire osf_mv_t targetMv,
  input wire osf_mv_t ovAdd,
  output osf_mv_t voutMv,
  output logic rampDone
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] rampCnt_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rampCnt_q <= 4'h0;
    else if (!outputEnable) rampCnt_q <= 4'h0;
    else if (!rampCnt_q[3]) rampCnt_q <= rampCnt_q + 4'h1;
  end
  assign rampDone = rampCnt_q[3];
  // Output collapses when off, so no stale level stays
  assign voutMv = outputEnable ? targetMv + ovAdd : 13'h0;
endmodule

// file: tb/output_setpoint_fault_supervisor_test.sv
// Self-checking bench of the setpoint and fault supervisor
module output_setpoint_fault_supervisor_test;
  timeunit 1ns;
  timeprecision 100ps;
  import osf_pkg::*;
  localparam int RST = 50;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, syncIn = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, ctrlPin = 0, shareMode = 0, twoPhase = 0, rampDone, outputEnable;
  logic outputGoodOut, outputGoodOe, syncOe, hiccupActive, syncOut, switchClk;
  logic [5:0] voltStrapCode = 6'h0;
  logic [2:0] freqStrapCode = 3'h2;
  osf_mv_t voutMv, targetMv, ovAdd = 13'h0;
  osf_amp_t ioutDa = 12'sh0;
  logic [10:0] freqKhz;
  logic [11:0] effFreqKhz;
  int errors = 0, tests_run = 0, n;
  logic [7:0] rowA [12] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28,
    8'h2c, 8'h34, 8'h4c};
  logic [31:0] rowV [12] = '{32'h3, 32'h3e8, 32'h47e, 32'h41a, 32'h3b6, 32'h44c, 32'h352,
    32'h384, 32'h3, 32'h190, 32'h1, 32'h43e8};
  always #4 clk_sys = ~clk_sys;
  osf_supervisor #(.RESTART_CYCLES(RST)) dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltStrapCode(voltStrapCode),
    .freqStrapCode(freqStrapCode), .ctrlPin(ctrlPin), .syncIn(syncIn), .shareMode(shareMode),
    .twoPhase(twoPhase), .voutMv(voutMv), .ioutDa(ioutDa), .rampDone(rampDone),
    .outputEnable(outputEnable), .targetMv(targetMv), .outputGoodOut(outputGoodOut),
    .outputGoodOe(outputGoodOe), .syncOut(syncOut), .syncOe(syncOe), .switchClk(switchClk),
    .freqKhz(freqKhz), .effFreqKhz(effFreqKhz), .hiccupActive(hiccupActive));
  osf_load_model load (.clk_sys(clk_sys), .rst(rst), .outputEnable(outputEnable),
    .targetMv(targetMv), .ovAdd(ovAdd), .voutMv(voutMv), .rampDone(rampDone));
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk_sys);
    q = prdata;
    if (k == 20) chk("pready", 1, 0);
    if (k == 20) complete_run();
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // Sample on negedge so registered outputs have settled
  task automatic wait_on(input logic v, input bit pg);
    for (n = 0; n < 2000; n++) begin
      @(negedge clk_sys);
      if ((pg ? outputGoodOut : outputEnable) === v) break;
    end
    if (n == 2000) chk(pg ? "outputGoodOut" : "outputEnable", 32'(v), 32'(!v));
    if (n == 2000) complete_run();
  endtask
  task automatic set_chk(input logic [7:0] a, input logic [31:0] d, input logic [12:0] e);
    apb(1, a, d);
    repeat (4) @(negedge clk_sys);
    chk("targetMv", 32'(e), 32'(targetMv));
  endtask
  task automatic trip(input osf_mv_t ov, input osf_amp_t i, input logic hic);
    @(posedge clk_sys);
    ovAdd <= ov;
    ioutDa <= i;
    wait_on(0, 0);
    repeat (2) @(negedge clk_sys);
    chk("hiccupActive", 32'(hic), 32'(hiccupActive));
    @(posedge clk_sys);
    ovAdd <= 13'h0;
    ioutDa <= 12'sh0;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 0;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 12; i++) rd(rowA[i], rowV[i]);
    rd(8'h50, 32'h0);
    chk("freqKhz", 32'h1c9, 32'(freqKhz));
    chk("syncOe", 0, 32'(syncOe));
    $display("test reset values finished");
    voltStrapCode <= 6'h1;
    repeat (6) @(posedge clk_sys);
    rd(REG_STRAP, 32'h43e8);
    apb(1, REG_VOUT_CMD, 32'h514);
    rd(REG_VOUT_CMD, 32'h514);
    set_chk(REG_OPERATION, 32'h0, 13'h47e);
    set_chk(REG_VOUT_MAX, 32'h44c, 13'h44c);
    apb(1, REG_VOUT_CMD, 32'h3e8);
    set_chk(REG_TRIM, 32'h14, 13'h3fc);
    set_chk(REG_OPERATION, 32'h4, 13'h42e);
    set_chk(REG_OPERATION, 32'h2, 13'h3ca);
    set_chk(REG_OPERATION, 32'h0, 13'h3fc);
    @(posedge clk_sys);
    twoPhase <= 1;
    apb(1, REG_FREQ, 32'h8258);
    apb(1, REG_SYNC_CFG, 32'h2);
    repeat (6) @(negedge clk_sys);
    chk("freqKhz", 32'h258, 32'(freqKhz));
    chk("effFreqKhz", 32'h4b0, 32'(effFreqKhz));
    chk("syncOe", 1, 32'(syncOe));
    q = 32'h0;
    repeat (300) begin
      @(negedge clk_sys);
      q = q + 32'(syncOut);
    end
    chk("syncOutToggles", 1, 32'(q > 0 && q < 300));
    apb(1, REG_SYNC_CFG, 32'h1);
    syncIn <= 1;
    repeat (5) @(negedge clk_sys);
    chk("switchClkHigh", 1, 32'(switchClk));
    @(posedge clk_sys);
    syncIn <= 0;
    repeat (5) @(negedge clk_sys);
    chk("switchClkLow", 0, 32'(switchClk));
    $display("test setpoint and clock finished");
    @(posedge clk_sys);
    ctrlPin <= 1;
    wait_on(1, 0);
    chk("outputGoodOut", 0, 32'(outputGoodOut));
    wait_on(1, 1);
    chk("pgDelay", 1, 32'(n >= PG_UNIT_CYCLES));
    apb(1, REG_USER_CFG, 32'h1);
    repeat (3) @(negedge clk_sys);
    chk("outputGoodOe", 0, 32'(outputGoodOe));
    apb(1, REG_USER_CFG, 32'h0);
    repeat (3) @(negedge clk_sys);
    chk("outputGoodOe", 1, 32'(outputGoodOe));
    $display("test power good finished");
    trip(13'h64, 12'sh0, 1);
    wait_on(1, 0);
    chk("restartWait", 1, 32'(n >= RST - 10));
    trip(13'h1ed4, 12'sh0, 1);
    wait_on(1, 0);
    trip(13'h0, 12'sh1f4, 0);
    repeat (100) @(negedge clk_sys);
    chk("latched", 0, 32'(outputEnable));
    apb(1, REG_CLEAR, 32'h1);
    wait_on(1, 0);
    trip(13'h0, 12'shed4, 0);
    apb(1, REG_CLEAR, 32'h1);
    wait_on(1, 0);
    @(posedge clk_sys);
    shareMode <= 1;
    repeat (4) @(posedge clk_sys);
    trip(13'h64, 12'sh0, 0);
    shareMode <= 0;
    apb(1, REG_CLEAR, 32'h1);
    wait_on(1, 0);
    $display("test faults finished");
    apb(1, REG_ONOFF, 32'h2);
    wait_on(0, 0);
    @(posedge clk_sys);
    ctrlPin <= 0;
    wait_on(1, 0);
    $display("test polarity finished");
    @(posedge clk_sys);
    rst <= 1;
    repeat (2) @(negedge clk_sys);
    chk("rstOutputEnable", 0, 32'(outputEnable));
    chk("rstGoodOe", 1, 32'(outputGoodOe));
    chk("rstGoodOut", 0, 32'(outputGoodOut));
    @(posedge clk_sys);
    rst <= 0;
    repeat (6) @(posedge clk_sys);
    rd(REG_STRAP, 32'h44b0);
    rd(REG_VOUT_MAX, 32'h564);
    chk("outputEnable", 0, 32'(outputEnable));
    $display("test reset finished");
    complete_run();
  end
endmodule
